/* File: logic/acc_pkg.sv */
// Shared constants, tables and helpers of the converter calibration controller.
package acc_pkg;

  // ----------------------------------------------------------------
  // Widths and command codes
  // ----------------------------------------------------------------
  localparam int DATA_W = 24;
  localparam int RATE_W = 4;
  localparam logic [2:0] CMD_SELF_OFS  = 3'h1;
  localparam logic [2:0] CMD_SELF_GAIN = 3'h2;
  localparam logic [2:0] CMD_SELF_FULL = 3'h3;
  localparam logic [2:0] CMD_SYS_OFS   = 3'h4;
  localparam logic [2:0] CMD_SYS_GAIN  = 3'h5;

  // ----------------------------------------------------------------
  // Reset values and per-rate-group constants
  // ----------------------------------------------------------------
  localparam logic [23:0] OFC_RESET      = 24'h00_0000;
  localparam logic [23:0] FSC_RESET      = 24'h44_AC08;
  localparam logic [23:0] FULL_SCALE_POS = 24'h7F_FFFF;
  localparam logic [23:0] ALPHA_G0 = 24'h40_0000;
  localparam logic [23:0] ALPHA_G1 = 24'h3C_0000;
  localparam logic [23:0] ALPHA_G2 = 24'h4B_0000;
  localparam logic [23:0] ALPHA_G3 = 24'h3E_8000;
  localparam logic [23:0] ALPHA_G4 = 24'h5D_C000;
  // Beta in Q16 (1.8639, 1.7474, 2.1843, 1.8202, 2.7304).
  localparam logic [17:0] BETA_G0 = 18'h1_DD29;
  localparam logic [17:0] BETA_G1 = 18'h1_BF56;
  localparam logic [17:0] BETA_G2 = 18'h2_2F2E;
  localparam logic [17:0] BETA_G3 = 18'h1_D1F9;
  localparam logic [17:0] BETA_G4 = 18'h2_BAFB;
  // Two to the 23 divided by alpha, in Q16.
  localparam logic [17:0] INV_ALPHA_G0 = 18'h2_0000;
  localparam logic [17:0] INV_ALPHA_G1 = 18'h2_2222;
  localparam logic [17:0] INV_ALPHA_G2 = 18'h1_B4E8;
  localparam logic [17:0] INV_ALPHA_G3 = 18'h2_0C4A;
  localparam logic [17:0] INV_ALPHA_G4 = 18'h1_5D86;

  // ----------------------------------------------------------------
  // Calibration times in units of 100 ns at the nominal master clock
  // ----------------------------------------------------------------
  localparam longint MCLK_NOM_KHZ = 7680;
  localparam longint OFS_CAL_T_100NS [16] = '{3870, 4530, 5870, 8530, 13000, 23000, 43000,
    203000, 337000, 403000, 670000, 803000, 1337000, 2003000, 4003000, 8003000};
  localparam longint GAIN_CAL_T_100NS [16] = '{4170, 4840, 6170, 8840, 14000, 24000, 44000,
    204000, 337000, 404000, 670000, 804000, 1337000, 2004000, 4004000, 8004000};

  // Master clock cycles of a duration, rounded down, never below one.
  function automatic logic [31:0] cal_cycles(input longint t_100ns, input int div);
    longint c;
    c = (t_100ns * MCLK_NOM_KHZ) / (longint'(10000) * longint'(div));
    if (c < 1) begin
      c = 1;
    end
    return c[31:0];
  endfunction

  // Rate index 0 is the fastest rate, 15 the slowest.
  function automatic logic [2:0] rate_group(input logic [3:0] rate);
    case (rate)
      4'h0, 4'h1, 4'h2, 4'h3: return 3'd0;
      4'h4, 4'h5, 4'h6:       return 3'd1;
      4'h7, 4'h9, 4'hB:       return 3'd2;
      4'h8, 4'hA, 4'hC:       return 3'd3;
      default:                return 3'd4;
    endcase
  endfunction

endpackage

/* File: logic/acc_div.sv */
// Sequential restoring divider used to derive the gain correction word.
`timescale 1ns/1ps
module acc_div (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request.
  input  wire logic        start,
  input  wire logic [63:0] num,
  input  wire logic [47:0] den,
  // Answer.
  output logic             done,
  output logic [63:0]      quo
);

  logic [48:0] rem_q;
  logic [63:0] num_q;
  logic [6:0]  cnt_q;
  logic        busy_q;
  logic [48:0] trial;
  logic [47:0] den_q;

  // One quotient bit per cycle; 64 cycles per division.
  assign trial = {rem_q[47:0], num_q[63]} - {1'b0, den_q};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q  <= '0;
      num_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done   <= 1'b0;
      quo    <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_q  <= '0;
        num_q  <= num;
        den_q  <= den;
        cnt_q  <= 7'd64;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (!trial[48]) begin
          rem_q <= trial;
        end else begin
          rem_q <= {rem_q[47:0], num_q[63]};
        end
        num_q <= {num_q[62:0], ~trial[48]};
        cnt_q <= cnt_q - 7'd1;
        if (cnt_q == 7'd1) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
          quo    <= {num_q[62:0], ~trial[48]};
        end
      end
    end
  end

endmodule

/* File: logic/acc_corr.sv */
// Two-stage correction datapath: offset removal, gain scaling, saturation.
`timescale 1ns/1ps
module acc_corr (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Raw sample and coefficients.
  input  wire logic        in_valid,
  input  wire logic [23:0] raw,
  input  wire logic [23:0] offset_correction,
  input  wire logic [23:0] gain_correction,
  input  wire logic [17:0] inv_alpha,
  input  wire logic [17:0] beta,
  // Corrected sample.
  output logic             out_valid,
  output logic [23:0]      result
);

  logic signed [26:0] diff_q;
  logic        [41:0] gain_q;
  logic               v1_q;
  logic signed [41:0] ofs_prod;
  logic signed [69:0] full;
  logic signed [30:0] scaled;

  // Offset term is the offset word times two to the 23 over alpha.
  assign ofs_prod = $signed(offset_correction) * $signed({1'b0, inv_alpha});
  assign full     = diff_q * $signed({1'b0, gain_q});
  assign scaled   = full[69:39];

  // Stage one removes the offset and forms gain word times beta.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diff_q <= '0;
      gain_q <= '0;
      v1_q   <= 1'b0;
    end else begin
      v1_q <= in_valid;
      if (in_valid) begin
        diff_q <= 27'($signed(raw)) - 27'(ofs_prod >>> 16);
        gain_q <= gain_correction * beta;
      end
    end
  end

  // Stage two scales and clips instead of wrapping.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      result    <= '0;
    end else begin
      out_valid <= v1_q;
      if (v1_q) begin
        if (scaled > 31'sd8388607) begin
          result <= 24'h7F_FFFF;
        end else if (scaled < -31'sd8388608) begin
          result <= 24'h80_0000;
        end else begin
          result <= scaled[23:0];
        end
      end
    end
  end

endmodule

/* File: logic/acc_cal_ctrl.sv */
// Calibration controller and correction path of a 24-bit delta-sigma converter.
//
// Functional notes
// - Holds 24-bit offset and gain words, host-accessible.
// - Result equals (input minus offset/alpha) times gain, beta.
// - Offset word signed, gain word unsigned full range.
// - Four fastest rates: alpha 400000h, beta 1.8639.
// - Rates 2000/1000/500: alpha 3C0000h, beta 1.7474.
// - Rates 100/50/25: alpha 4B0000h, beta 2.1843.
// - Rates 60/30/15: alpha 3E8000h, beta 1.8202.
// - Rates 10/5/2.5: alpha 5DC000h, beta 2.7304.
// - Five calibration commands accepted any time.
// - Done flag held high throughout calibration.
// - Self calibration runs automatically after reset.
// - Self offset ties inputs mid-supply, updates offset.
// - Offset calibration time follows per-rate table.
// - Calibration times scale with master clock.
// - Self gain routes references, updates gain word.
// - Master clock copy driven on general pin zero; the code drives a registered half-rate copy.
// - Full self calibration: offset then gain.
// - System offset updates only offset word.
// - System gain updates only gain word.
// - Auto-cal enable retriggers on relevant config changes.
`timescale 1ns/1ps
module acc_cal_ctrl #(
  parameter int CAL_TIME_DIV = 1
) (
  // Clock and reset.
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // Converter configuration and its write strobe.
  input  wire logic [3:0]  DATA_RATE,
  input  wire logic [2:0]  PGA_GAIN,
  input  wire logic        BUFFER_EN,
  input  wire logic        AUTO_CAL_ENABLE,
  input  wire logic        CFG_WRITE,
  // Calibration commands.
  input  wire logic        CAL_CMD_VALID,
  input  wire logic [2:0]  CAL_CMD,
  // Correction word access.
  input  wire logic        OFFSET_CORRECTION_WORD_WR,
  input  wire logic [23:0] OFFSET_CORRECTION_WORD_WDATA,
  output logic      [23:0] OFFSET_CORRECTION_WORD_RDATA,
  input  wire logic        GAIN_CORRECTION_WORD_WR,
  input  wire logic [23:0] GAIN_CORRECTION_WORD_WDATA,
  output logic      [23:0] GAIN_CORRECTION_WORD_RDATA,
  // Modulator and filter side.
  input  wire logic        RAW_VALID,
  input  wire logic [23:0] RAW_DATA,
  output logic             INPUT_TIE_MID,
  output logic             INPUT_TIE_REF,
  output logic             CAL_BUSY,
  // Conversion output.
  output logic [23:0]      RESULT_DATA,
  output logic             CONVERSION_DONE_N,
  // General pin zero.
  output logic             GPIO0_CLOCK_OUT,
  output logic             GPIO0_CLOCK_OE
);

  // ----------------------------------------------------------------
  // Types and declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_OFS_WAIT  = 3'b001,
    ST_OFS_DONE  = 3'b011,
    ST_GAIN_WAIT = 3'b010,
    ST_GAIN_DIV  = 3'b110,
    ST_GAIN_DONE = 3'b111
  } acc_state_t;

  acc_state_t  state_q;
  logic        rst_s1_q;
  logic        rst_n_q;
  logic        boot_q;
  logic [2:0]  mode_q;
  logic [31:0] timer_q;
  logic [23:0] meas_q;
  logic [23:0] ofc_q;
  logic [23:0] fsc_q;
  logic [3:0]  rate_q;
  logic [2:0]  pga_q;
  logic        buf_q;
  logic        ofc_cal_wr;
  logic        fsc_cal_wr;
  logic [23:0] ofc_cal;
  logic [23:0] fsc_cal;
  logic        auto_trig;
  logic        cmd_ok;
  logic        start;
  logic [2:0]  start_mode;
  logic [2:0]  grp;
  logic [23:0] alpha;
  logic [17:0] beta;
  logic [17:0] inv_alpha;
  logic        div_start;
  logic        div_done;
  logic [63:0] div_quo;
  logic [47:0] div_den;
  logic        busy;
  logic        corr_valid;
  logic [23:0] corr_result;
  logic        clk_div_q;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Reset is asserted at once and released through two flops.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Rate-dependent constants
  // ----------------------------------------------------------------
  // Alpha, beta and the offset scale come from the rate group.
  always_comb begin
    grp = acc_pkg::rate_group(DATA_RATE);
    unique case (grp)
      3'd0: begin
        alpha     = acc_pkg::ALPHA_G0;
        beta      = acc_pkg::BETA_G0;
        inv_alpha = acc_pkg::INV_ALPHA_G0;
      end
      3'd1: begin
        alpha     = acc_pkg::ALPHA_G1;
        beta      = acc_pkg::BETA_G1;
        inv_alpha = acc_pkg::INV_ALPHA_G1;
      end
      3'd2: begin
        alpha     = acc_pkg::ALPHA_G2;
        beta      = acc_pkg::BETA_G2;
        inv_alpha = acc_pkg::INV_ALPHA_G2;
      end
      3'd3: begin
        alpha     = acc_pkg::ALPHA_G3;
        beta      = acc_pkg::BETA_G3;
        inv_alpha = acc_pkg::INV_ALPHA_G3;
      end
      default: begin
        alpha     = acc_pkg::ALPHA_G4;
        beta      = acc_pkg::BETA_G4;
        inv_alpha = acc_pkg::INV_ALPHA_G4;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Calibration triggers
  // ----------------------------------------------------------------
  // A configuration write only retriggers when a relevant field changes.
  assign auto_trig = CFG_WRITE && AUTO_CAL_ENABLE
                     && (DATA_RATE != rate_q || PGA_GAIN != pga_q
                         || BUFFER_EN != buf_q);
  assign cmd_ok = CAL_CMD_VALID && (CAL_CMD >= acc_pkg::CMD_SELF_OFS)
                  && (CAL_CMD <= acc_pkg::CMD_SYS_GAIN);
  // A command wins over an automatic trigger; any start aborts a running calibration.
  assign start      = boot_q || cmd_ok || auto_trig;
  assign start_mode = cmd_ok ? CAL_CMD : acc_pkg::CMD_SELF_FULL;

  // Shadow of the configuration last written, used for change detection.
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rate_q <= 4'h0;
      pga_q  <= 3'h0;
      buf_q  <= 1'b0;
    end else if (CFG_WRITE) begin
      rate_q <= DATA_RATE;
      pga_q  <= PGA_GAIN;
      buf_q  <= BUFFER_EN;
    end
  end

  // The boot request stands for one cycle after reset release.
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  // Timer loads from the per-rate tables in master clock cycles.
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      mode_q  <= 3'h0;
      timer_q <= '0;
    end else if (start) begin
      mode_q <= start_mode;
      if (start_mode == acc_pkg::CMD_SELF_GAIN || start_mode == acc_pkg::CMD_SYS_GAIN) begin
        state_q <= ST_GAIN_WAIT;
        timer_q <= acc_pkg::cal_cycles(acc_pkg::GAIN_CAL_T_100NS[DATA_RATE],
                                       CAL_TIME_DIV);
      end else begin
        state_q <= ST_OFS_WAIT;
        timer_q <= acc_pkg::cal_cycles(acc_pkg::OFS_CAL_T_100NS[DATA_RATE],
                                       CAL_TIME_DIV);
      end
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        ST_OFS_WAIT: begin
          timer_q <= timer_q - 32'd1;
          if (timer_q == 32'd1) begin
            state_q <= ST_OFS_DONE;
          end
        end
        ST_OFS_DONE: begin
          if (mode_q == acc_pkg::CMD_SELF_FULL) begin
            state_q <= ST_GAIN_WAIT;
            timer_q <= acc_pkg::cal_cycles(acc_pkg::GAIN_CAL_T_100NS[DATA_RATE],
                                           CAL_TIME_DIV);
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_GAIN_WAIT: begin
          timer_q <= timer_q - 32'd1;
          if (timer_q == 32'd1) begin
            state_q <= ST_GAIN_DIV;
          end
        end
        ST_GAIN_DIV: begin
          if (div_done) begin
            state_q <= ST_GAIN_DONE;
          end
        end
        ST_GAIN_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_q != ST_IDLE);

  // Front end routing during the measuring phases; system modes keep the source.
  always_comb begin
    INPUT_TIE_MID = (state_q == ST_OFS_WAIT) && (mode_q != acc_pkg::CMD_SYS_OFS);
    INPUT_TIE_REF = (state_q == ST_GAIN_WAIT) && (mode_q != acc_pkg::CMD_SYS_GAIN);
  end

  // The last filter sample of a measuring phase is the calibration reading.
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      meas_q <= '0;
    end else if (RAW_VALID && (state_q == ST_OFS_WAIT || state_q == ST_GAIN_WAIT)) begin
      meas_q <= RAW_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Coefficient arithmetic
  // ----------------------------------------------------------------
  logic signed [47:0] ofs_prod;
  logic signed [24:0] ofs_new;
  logic signed [41:0] ofs_term;
  logic signed [26:0] fs_diff;
  logic        [44:0] den_full;

  // Offset word that nulls the reading: reading times alpha over two to the 23.
  assign ofs_prod = $signed(meas_q) * $signed({1'b0, alpha});
  assign ofs_new  = ofs_prod[47:23];
  always_comb begin
    if (ofs_new > 25'sd8388607) begin
      ofc_cal = 24'h7F_FFFF;
    end else if (ofs_new < -25'sd8388608) begin
      ofc_cal = 24'h80_0000;
    end else begin
      ofc_cal = ofs_new[23:0];
    end
  end

  // Gain word so that the offset-free full-scale reading maps to full scale.
  assign ofs_term  = $signed(ofc_q) * $signed({1'b0, inv_alpha});
  assign fs_diff   = 27'($signed(meas_q)) - 27'(ofs_term >>> 16);
  assign den_full  = (fs_diff > 27'sd0) ? 45'(fs_diff[25:0]) * 45'(beta) : 45'd1;
  assign div_den   = {3'h0, den_full};
  assign div_start = (state_q == ST_GAIN_WAIT) && (timer_q == 32'd1) && !start;

  acc_div u_div (
    .clk   (SYS_CLK),
    .rst_n (rst_n_q),
    .start (div_start),
    .num   ({2'h0, acc_pkg::FULL_SCALE_POS[22:0], 39'h0}),
    .den   (div_den),
    .done  (div_done),
    .quo   (div_quo)
  );

  // A weak or negative reading clips the gain word at its unsigned top.
  assign fsc_cal    = (fs_diff <= 27'sd0 || div_quo[63:24] != '0) ? 24'hFF_FFFF
                                                                   : div_quo[23:0];
  assign ofc_cal_wr = (state_q == ST_OFS_DONE) && !start;
  assign fsc_cal_wr = (state_q == ST_GAIN_DONE) && !start;

  // ----------------------------------------------------------------
  // Correction words
  // ----------------------------------------------------------------
  // Calibration results override a host write landing in the same cycle.
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ofc_q <= acc_pkg::OFC_RESET;
    end else if (ofc_cal_wr) begin
      ofc_q <= ofc_cal;
    end else if (OFFSET_CORRECTION_WORD_WR) begin
      ofc_q <= OFFSET_CORRECTION_WORD_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fsc_q <= acc_pkg::FSC_RESET;
    end else if (fsc_cal_wr) begin
      fsc_q <= fsc_cal;
    end else if (GAIN_CORRECTION_WORD_WR) begin
      fsc_q <= GAIN_CORRECTION_WORD_WDATA;
    end
  end

  assign OFFSET_CORRECTION_WORD_RDATA = ofc_q;
  assign GAIN_CORRECTION_WORD_RDATA   = fsc_q;
  assign CAL_BUSY                     = busy;

  // ----------------------------------------------------------------
  // Conversion path
  // ----------------------------------------------------------------
  // Samples taken during calibration never reach the output.
  acc_corr u_corr (
    .clk       (SYS_CLK),
    .rst_n     (rst_n_q),
    .in_valid  (RAW_VALID && !busy && !start),
    .raw       (RAW_DATA),
    .offset_correction       (ofc_q),
    .gain_correction       (fsc_q),
    .inv_alpha (inv_alpha),
    .beta      (beta),
    .out_valid (corr_valid),
    .result    (corr_result)
  );

  // Done goes high with a calibration and low again with fresh settled data.
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      CONVERSION_DONE_N <= 1'b1;
      RESULT_DATA       <= '0;
    end else if (start || busy) begin
      CONVERSION_DONE_N <= 1'b1;
    end else if (RAW_VALID) begin
      CONVERSION_DONE_N <= 1'b1;
    end else if (corr_valid) begin
      CONVERSION_DONE_N <= 1'b0;
      RESULT_DATA       <= corr_result;
    end
  end

  // ----------------------------------------------------------------
  // Clock output on general pin zero
  // ----------------------------------------------------------------
  // A registered half-rate copy keeps the clock net out of data logic.
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= ~clk_div_q;
    end
  end

  assign GPIO0_CLOCK_OUT = clk_div_q;
  assign GPIO0_CLOCK_OE  = rst_n_q;

endmodule

/* File: testbench/acc_cal_ctrl_checker.sv */
// Port checker of the calibration controller.
`timescale 1ns/1ps
module acc_cal_ctrl_checker (
  // Clock, reset and requests.
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        CAL_CMD_VALID,
  input wire logic [2:0]  CAL_CMD,
  input wire logic        RAW_VALID,
  input wire logic        OFFSET_CORRECTION_WORD_WR,
  input wire logic [23:0] OFFSET_CORRECTION_WORD_WDATA,
  // Answers.
  input wire logic [23:0] OFFSET_CORRECTION_WORD_RDATA,
  input wire logic        INPUT_TIE_MID,
  input wire logic        INPUT_TIE_REF,
  input wire logic        CAL_BUSY,
  input wire logic        CONVERSION_DONE_N,
  input wire logic        GPIO0_CLOCK_OUT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  a_done_hold_cal: assert property (CAL_BUSY |-> CONVERSION_DONE_N)
    else $error("done flag low during calibration");
  a_cmd_starts_cal: assert property (CAL_CMD_VALID && CAL_CMD inside {[3'h1:3'h5]}
    |=> CAL_BUSY)
    else $error("command did not start calibration");
  a_mid_tie_phase: assert property (INPUT_TIE_MID |-> CAL_BUSY && !INPUT_TIE_REF)
    else $error("inputs tied to mid supply outside calibration");
  a_ref_tie_phase: assert property (INPUT_TIE_REF |-> CAL_BUSY)
    else $error("inputs tied to references outside calibration");
  a_clock_out_runs: assert property ($rose(GPIO0_CLOCK_OUT)
    |=> $fell(GPIO0_CLOCK_OUT) ##1 $rose(GPIO0_CLOCK_OUT))
    else $error("clock copy stopped");
  a_sample_to_done: assert property (RAW_VALID && !CAL_BUSY && !CAL_CMD_VALID
    |=> CONVERSION_DONE_N ##2 (!CONVERSION_DONE_N || CAL_BUSY))
    else $error("sample gave no result");
  a_done_has_cause: assert property ($fell(CONVERSION_DONE_N) |-> $past(RAW_VALID, 3))
    else $error("result without sample");
  a_offset_write: assert property (OFFSET_CORRECTION_WORD_WR && !CAL_BUSY
    |=> OFFSET_CORRECTION_WORD_RDATA == $past(OFFSET_CORRECTION_WORD_WDATA))
    else $error("offset word write lost");
endmodule

bind acc_cal_ctrl acc_cal_ctrl_checker i_chk (.*);

/* File: testbench/acc_raw_src.sv */
// Sample source standing in for the modulator and filter.
`timescale 1ns/1ps
module acc_raw_src #(
  parameter logic [23:0] MID_CODE = 24'h00_0200,
  parameter logic [23:0] REF_CODE = 24'h40_0000
) (
  // Clock and controls.
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic        tie_mid,
  input  wire logic        tie_ref,
  input  wire logic [23:0] level,
  // Samples.
  output logic             raw_valid,
  output logic [23:0]      raw_data
);
  logic [1:0] cnt_q = 2'd0;

  // One sample every fourth cycle; between samples the data is scrambled, not held.
  always_ff @(posedge clk) begin
    cnt_q <= run ? cnt_q + 2'd1 : 2'd0;
    raw_valid <= run && (cnt_q == 2'd3);
    raw_data <= (cnt_q == 2'd3) ? (tie_ref ? REF_CODE : (tie_mid ? MID_CODE : level))
                                : ~raw_data;
  end
endmodule

/* File: testbench/test_acc_cal_ctrl.sv */
// Self-checking bench of the calibration controller.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module test_acc_cal_ctrl;
  logic        clk = 1'b0, rst_n = 1'b0, buf_en = 1'b0, auto_cal_enable = 1'b0, cfg_wr = 1'b0;
  logic        cmd_v = 1'b0, ow = 1'b0, gw = 1'b0, run = 1'b0;
  logic [3:0]  rate = 4'h0;
  logic [2:0]  pga = 3'h0, cmd = 3'h0;
  logic [23:0] ow_d = 24'h00_0000, gw_d = 24'h00_0000, level = 24'h00_0000;
  logic [23:0] o_rd, g_rd, res, raw_d, keep;
  logic        tie_mid, tie_ref, busy, done_n, ck_out, ck_oe, raw_v;
  int          error_cnt = 0, n_tests = 0;

  acc_cal_ctrl #(.CAL_TIME_DIV(1000)) i_dut (.SYS_CLK(clk), .RESET_N(rst_n),
    .DATA_RATE(rate), .PGA_GAIN(pga), .BUFFER_EN(buf_en), .AUTO_CAL_ENABLE(auto_cal_enable),
    .CFG_WRITE(cfg_wr), .CAL_CMD_VALID(cmd_v), .CAL_CMD(cmd),
    .OFFSET_CORRECTION_WORD_WR(ow), .OFFSET_CORRECTION_WORD_WDATA(ow_d),
    .OFFSET_CORRECTION_WORD_RDATA(o_rd), .GAIN_CORRECTION_WORD_WR(gw),
    .GAIN_CORRECTION_WORD_WDATA(gw_d), .GAIN_CORRECTION_WORD_RDATA(g_rd),
    .RAW_VALID(raw_v), .RAW_DATA(raw_d), .INPUT_TIE_MID(tie_mid), .INPUT_TIE_REF(tie_ref),
    .CAL_BUSY(busy), .RESULT_DATA(res), .CONVERSION_DONE_N(done_n),
    .GPIO0_CLOCK_OUT(ck_out), .GPIO0_CLOCK_OE(ck_oe));
  acc_raw_src i_src (.clk(clk), .run(run), .tie_mid(tie_mid), .tie_ref(tie_ref),
    .level(level), .raw_valid(raw_v), .raw_data(raw_d));

  initial forever #10 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared drivers; inputs move on the falling edge only.
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A bound that runs out counts as a mismatch and ends the run.
  task automatic wait_idle;
    int i;
    for (i = 0; i < 20000 && busy !== 1'b0; i++) tick(1);
    if (i == 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic wr_words(input logic [23:0] o, input logic [23:0] g);
    {ow, gw, ow_d, gw_d} = {2'b11, o, g};
    tick(1);
    {ow, gw} = 2'b00;
  endtask
  task automatic issue(input logic [2:0] c);
    {cmd_v, cmd} = {1'b1, c};
    tick(1);
    cmd_v = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_boot;
    `CHK(o_rd, 24'h00_0000)
    `CHK(g_rd, 24'h44_AC08)
    `CHK(ck_oe, 1'b0)
    rst_n = 1'b1;
    tick(5);
    `CHK(busy, 1'b1)
    `CHK(done_n, 1'b1)
    `CHK(ck_oe, 1'b1)
    wait_idle;
    // Host recalibrates once the reference is taken as settled.
    issue(acc_pkg::CMD_SELF_FULL);
    wait_idle;
  endtask
  // A negative offset word must raise the result, so signedness shows.
  task automatic t_conv;
    longint e;
    e = ((64'sh10_0000 - ((-64'sd4096 * longint'(acc_pkg::INV_ALPHA_G0)) >>> 16))
      * 64'sh44_AC08 * longint'(acc_pkg::BETA_G0)) >>> 39;
    run = 1'b1;
    level = 24'h10_0000;
    wr_words(24'hFF_F000, 24'h44_AC08);
    `CHK(g_rd, 24'h44_AC08)
    tick(10);
    `CHK(res, e[23:0])
    wr_words(24'h00_0000, 24'hFF_FFFF);
    level = 24'h7F_FFFF;
    tick(10);
    `CHK(res, 24'h7F_FFFF)
    level = 24'h80_0000;
    tick(10);
    `CHK(res, 24'h80_0000)
  endtask
  task automatic t_cmds;
    wr_words(24'h00_0ABC, 24'h12_3456);
    issue(acc_pkg::CMD_SYS_GAIN);
    wait_idle;
    `CHK(o_rd, 24'h00_0ABC)
    keep = g_rd;
    issue(acc_pkg::CMD_SYS_OFS);
    wait_idle;
    `CHK(g_rd, keep)
    keep = o_rd;
    issue(acc_pkg::CMD_SELF_GAIN);
    `CHK(tie_ref, 1'b1)
    wait_idle;
    `CHK(o_rd, keep)
    issue(acc_pkg::CMD_SELF_FULL);
    `CHK(tie_mid, 1'b1)
    for (int i = 0; i < 200 && tie_ref !== 1'b1; i++) tick(1);
    `CHK(tie_ref, 1'b1)
    wait_idle;
    issue(3'h6);
    `CHK(busy, 1'b0)
  endtask
  // The slowest rate gives the longest offset count, scaled down a thousandfold.
  task automatic t_ofs_time;
    int n;
    {cfg_wr, rate} = {1'b1, 4'hF};
    tick(1);
    cfg_wr = 1'b0;
    issue(acc_pkg::CMD_SELF_OFS);
    `CHK(tie_mid, 1'b1)
    for (n = 0; n < 8000 && busy === 1'b1; n++) tick(1);
    `CHK(n, 8003 * 768 / 1000 + 1)
    `CHK(o_rd, 24'h00_0177)
  endtask
  task automatic t_autocal;
    {auto_cal_enable, buf_en, cfg_wr} = 3'b111;
    tick(1);
    cfg_wr = 1'b0;
    `CHK(busy, 1'b1)
    wait_idle;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    `CHK(busy, 1'b0)
    {pga, cfg_wr} = {3'h1, 1'b1};
    tick(1);
    cfg_wr = 1'b0;
    `CHK(busy, 1'b1)
    wait_idle;
  endtask

  initial begin
    tick(3);
    t_boot;
    t_conv;
    t_cmds;
    t_ofs_time;
    t_autocal;
    tally_and_finish;
  end
endmodule
